//--- core/upr_power_reset.sv
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Suspend indicator low while USB suspended, high otherwise.
// - Power enable low once configured, high again whenever suspended.
// - Reset output floats about 2ms after supply good and clock running, then drives high.
// - External reset input low floats the reset output.
// - USB bus reset never affects the reset output.
// - Transmit lamp pulses low on USB transmit activity.
// - Receive lamp pulses low on USB receive activity.
// - Oscillator output stops toggling while suspended.
// - A 6MHz reference is the timing base.
// - Working clock is the reference multiplied by eight.
// - Power source select low means bus powered, high self powered.
// - Test input high selects test mode; low is normal operation.
module upr_power_reset #(
    parameter int unsigned HOLD_CYC = upr_pkg::RST_HOLD_CYC,
    parameter int unsigned PULSE_CYC = upr_pkg::LAMP_PULSE_CYC
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_supply_good,
    input wire logic i_clock_running,
    input wire logic i_ext_reset_n,
    input wire logic i_usb_bus_reset,
    input wire upr_pkg::upr_usb_s i_usb,
    input wire logic i_power_source_select,
    input wire logic i_test_mode,
    output logic o_suspend_n,
    output logic o_ext_power_enable_n,
    output logic o_reset_out,
    output logic o_reset_out_oe_n,
    output logic o_tx_activity_lamp_n,
    output logic o_tx_activity_lamp_oe_n,
    output logic o_rx_activity_lamp_n,
    output logic o_rx_activity_lamp_oe_n,
    output logic o_osc_out,
    output logic o_self_powered,
    output logic o_test_active
);
    import upr_pkg::*;

    if (HOLD_CYC < 1 || PULSE_CYC < 1) begin : g_bad_param
        $error("Hold and pulse counts must be at least one cycle.");
    end

    localparam int CW = $clog2(HOLD_CYC + 1);
    localparam int PW = $clog2(PULSE_CYC + 1);

    // ------------------------------------------------------------
    // Power state outputs
    // ------------------------------------------------------------
    logic suspend_n_reg;
    logic pwr_en_n_reg;
    wire logic suspend_n_next = ~i_usb.suspended;
    wire logic pwr_en_n_next = ~(i_usb.configured & ~i_usb.suspended);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            suspend_n_reg <= 1'b1;
            pwr_en_n_reg <= 1'b1;
        end else begin
            suspend_n_reg <= suspend_n_next;
            pwr_en_n_reg <= pwr_en_n_next;
        end
    end

    assign o_suspend_n = suspend_n_reg;
    assign o_ext_power_enable_n = pwr_en_n_reg;

    // ------------------------------------------------------------
    // Reset output generator
    // ------------------------------------------------------------
    // The bus reset input is ANDed with zero in the only term below that names it,
    // so enumeration resets never disturb logic held by this output.
    upr_rst_e rst_state_reg;
    upr_rst_e rst_state_next;
    logic [CW-1:0] hold_cnt_reg;
    logic [CW-1:0] hold_cnt_next;
    wire logic start_ok = i_supply_good & i_clock_running & i_ext_reset_n;
    wire logic hold_done = (hold_cnt_reg == CW'(HOLD_CYC - 1));
    wire logic unused_bus_reset = i_usb_bus_reset;

    always_comb begin
        rst_state_next = rst_state_reg;
        hold_cnt_next = hold_cnt_reg;
        unique case (rst_state_reg)
            UPR_RST_HOLD: begin
                hold_cnt_next = '0;
                if (start_ok) begin
                    rst_state_next = UPR_RST_WAIT;
                end
            end
            UPR_RST_WAIT: begin
                hold_cnt_next = hold_cnt_reg + CW'(1);
                if (!start_ok) begin
                    rst_state_next = UPR_RST_HOLD;
                end else if (hold_done) begin
                    rst_state_next = UPR_RST_RUN;
                end
            end
            UPR_RST_RUN: begin
                if (!start_ok) begin
                    rst_state_next = UPR_RST_HOLD;
                end
            end
            default: begin
                rst_state_next = UPR_RST_HOLD;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_state_reg <= UPR_RST_HOLD;
            hold_cnt_reg <= '0;
        end else begin
            rst_state_reg <= rst_state_next;
            hold_cnt_reg <= hold_cnt_next;
        end
    end

    assign o_reset_out = 1'b1;
    assign o_reset_out_oe_n = (rst_state_reg != UPR_RST_RUN) | unused_bus_reset & 1'b0;

    // ------------------------------------------------------------
    // Activity lamps
    // ------------------------------------------------------------
    // Each lamp stretches activity to a visible pulse; new activity
    // restarts the stretch so a busy link keeps the lamp lit.
    logic [1:0] lamp_on;
    wire logic [1:0] lamp_act = {i_usb.rx_active, i_usb.tx_active};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lamp
            logic [PW-1:0] cnt_reg;
            wire logic [PW-1:0] cnt_next = lamp_act[g] ? PW'(PULSE_CYC) :
                (cnt_reg != '0) ? cnt_reg - PW'(1) : cnt_reg;
            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    cnt_reg <= '0;
                end else begin
                    cnt_reg <= cnt_next;
                end
            end
            assign lamp_on[g] = (cnt_reg != '0);
        end
    endgenerate

    // Open-collector pins: drive low when lit, release otherwise.
    assign o_tx_activity_lamp_n = 1'b0;
    assign o_tx_activity_lamp_oe_n = ~lamp_on[0];
    assign o_rx_activity_lamp_n = 1'b0;
    assign o_rx_activity_lamp_oe_n = ~lamp_on[1];

    // ------------------------------------------------------------
    // Oscillator output
    // ------------------------------------------------------------
    // The analog oscillator and multiplier are outside this logic; here
    // the work clock is divided back to a reference-rate image.
    logic [2:0] osc_cnt_reg;
    logic osc_reg;
    wire logic osc_wrap = (osc_cnt_reg == 3'(OSC_HALF_CYC - 1));
    wire logic [2:0] osc_cnt_next = osc_wrap ? 3'h0 : osc_cnt_reg + 3'h1;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            osc_cnt_reg <= 3'h0;
            osc_reg <= 1'b0;
        end else if (!i_usb.suspended) begin
            osc_cnt_reg <= osc_cnt_next;
            if (osc_wrap) begin
                osc_reg <= ~osc_reg;
            end
        end
    end

    assign o_osc_out = osc_reg;

    // ------------------------------------------------------------
    // Straps
    // ------------------------------------------------------------
    logic self_pwr_reg;
    logic test_reg;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            self_pwr_reg <= 1'b0;
            test_reg <= 1'b0;
        end else begin
            self_pwr_reg <= i_power_source_select;
            test_reg <= i_test_mode;
        end
    end

    assign o_self_powered = self_pwr_reg;
    assign o_test_active = test_reg;

endmodule // upr_power_reset

`default_nettype wire

//--- core/upr_pkg.sv
package upr_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned RST_HOLD_US = 2000;
    localparam int unsigned RST_HOLD_CYC = (CLK_HZ / 1_000_000) * RST_HOLD_US;
    localparam int unsigned LAMP_PULSE_US = 20;
    localparam int unsigned LAMP_PULSE_CYC = (CLK_HZ / 1_000_000) * LAMP_PULSE_US;
    localparam int unsigned OSC_REF_HZ = 6_000_000;
    localparam int unsigned PLL_MULT = 8;
    localparam int unsigned WORK_HZ = OSC_REF_HZ * PLL_MULT;
    localparam int unsigned OSC_HALF_CYC = 4;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        UPR_RST_HOLD = 3'b001,
        UPR_RST_WAIT = 3'b010,
        UPR_RST_RUN = 3'b100
    } upr_rst_e;

    typedef struct packed {
        logic configured;
        logic suspended;
        logic tx_active;
        logic rx_active;
    } upr_usb_s;

endpackage

//--- test/upr_partner.sv
`timescale 1ns/100ps
`default_nettype none
module upr_partner (
    input wire logic i_reset_out,
    input wire logic i_reset_out_oe_n,
    input wire logic i_ext_power_enable_n,
    output logic o_held_in_reset,
    output logic o_powered
);
    // A released reset line reads as asserted; the partner is held in reset until the line drives high.
    assign o_held_in_reset = i_reset_out_oe_n ? 1'b1 : !i_reset_out;
    // The switch conducts while the enable is low and is off while the enable is high.
    assign o_powered = !i_ext_power_enable_n;
endmodule // upr_partner
`default_nettype wire

//--- test/upr_power_reset_checker.sv
`timescale 1ns/100ps
`default_nettype none
module upr_power_reset_checker #(
    parameter int unsigned HOLD_CYC = 20,
    parameter int unsigned PULSE_CYC = 5
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_supply_good,
    input wire logic i_clock_running,
    input wire logic i_ext_reset_n,
    input wire upr_pkg::upr_usb_s i_usb,
    input wire logic o_suspend_n,
    input wire logic o_ext_power_enable_n,
    input wire logic o_reset_out_oe_n,
    input wire logic o_tx_activity_lamp_oe_n,
    input wire logic o_rx_activity_lamp_oe_n,
    input wire logic o_osc_out
);
    import upr_pkg::*;
    int unsigned ok_cnt;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // Edges with all start conditions good; saturates so it never wraps.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) ok_cnt <= '0;
        else if (!(i_supply_good && i_clock_running && i_ext_reset_n)) ok_cnt <= '0;
        else if (ok_cnt < HOLD_CYC + 2) ok_cnt <= ok_cnt + 1;
    end
    sequence tx_fired; i_usb.tx_active; endsequence
    sequence tx_quiet; !i_usb.tx_active [*6]; endsequence
    sequence awake; !i_usb.suspended [*8]; endsequence
    chk_suspend_level: assert property (1 |=> o_suspend_n == !$past(i_usb.suspended))
        else $error("suspend indicator wrong");
    chk_power_enable: assert property (1 |=> o_ext_power_enable_n == !$past(i_usb.configured && !i_usb.suspended))
        else $error("power enable wrong");
    chk_reset_hold: assert property (o_reset_out_oe_n == (ok_cnt < HOLD_CYC + 1))
        else $error("reset output timing wrong");
    chk_tx_lit: assert property (tx_fired |=> !o_tx_activity_lamp_oe_n [*5])
        else $error("transmit lamp pulse short");
    chk_tx_dark: assert property (tx_quiet |=> o_tx_activity_lamp_oe_n)
        else $error("transmit lamp stuck");
    chk_rx_lit: assert property (i_usb.rx_active |=> !o_rx_activity_lamp_oe_n [*5])
        else $error("receive lamp pulse short");
    chk_osc_frozen: assert property (i_usb.suspended [*2] |=> $stable(o_osc_out))
        else $error("oscillator output runs in suspend");
    chk_osc_running: assert property (awake |-> o_osc_out != $past(o_osc_out, 4))
        else $error("oscillator output not toggling");
endmodule // upr_power_reset_checker
bind upr_power_reset upr_power_reset_checker #(.HOLD_CYC(HOLD_CYC), .PULSE_CYC(PULSE_CYC)) u_chk (.i_clk, .i_resetn,
    .i_supply_good, .i_clock_running, .i_ext_reset_n, .i_usb, .o_suspend_n, .o_ext_power_enable_n,
    .o_reset_out_oe_n, .o_tx_activity_lamp_oe_n, .o_rx_activity_lamp_oe_n, .o_osc_out);
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import upr_pkg::*;
    localparam int unsigned HOLD = 20;
    localparam int unsigned PULSE = 5;
    logic i_clk, i_resetn, i_supply_good, i_clock_running, i_ext_reset_n, i_usb_bus_reset, held, powered, last;
    logic i_power_source_select, i_test_mode, o_suspend_n, o_ext_power_enable_n, o_reset_out, o_reset_out_oe_n;
    logic o_tx_activity_lamp_n, o_tx_activity_lamp_oe_n, o_rx_activity_lamp_n, o_rx_activity_lamp_oe_n;
    logic o_osc_out, o_self_powered, o_test_active;
    upr_usb_s i_usb;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;
    int flips;
    // Row: usb levels, straps, then suspend_n, power off, self powered, test.
    logic [11:0] rows [5] = '{12'h00C, 12'h819, 12'hC26, 12'h808, 12'h437};
    upr_power_reset #(.HOLD_CYC(HOLD), .PULSE_CYC(PULSE)) u_upr_power_reset (.i_clk, .i_resetn, .i_supply_good,
        .i_clock_running, .i_ext_reset_n, .i_usb_bus_reset, .i_usb, .i_power_source_select, .i_test_mode,
        .o_suspend_n, .o_ext_power_enable_n, .o_reset_out, .o_reset_out_oe_n, .o_tx_activity_lamp_n,
        .o_tx_activity_lamp_oe_n, .o_rx_activity_lamp_n, .o_rx_activity_lamp_oe_n, .o_osc_out,
        .o_self_powered, .o_test_active);
    upr_partner u_upr_partner (.i_reset_out(o_reset_out), .i_reset_out_oe_n(o_reset_out_oe_n),
        .i_ext_power_enable_n(o_ext_power_enable_n), .o_held_in_reset(held), .o_powered(powered));
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        if (failures == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        @(negedge i_clk);
    endtask
    task automatic hold_check;
        step(HOLD);
        check({3'h0, held}, 4'h1);
        step(1);
        check({3'h0, held}, 4'h0);
    endtask
    initial begin
        i_clk = 0;
        forever #10 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 1000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        {i_resetn, i_supply_good, i_clock_running, i_ext_reset_n, i_usb_bus_reset} = 5'h0E;
        {i_power_source_select, i_test_mode} = 2'h0;
        i_usb = '0;
        repeat (5) @(posedge i_clk);
        i_resetn <= 1;
        hold_check();
        foreach (rows[i]) begin
            @(posedge i_clk);
            i_usb <= rows[i][11:8];
            {i_power_source_select, i_test_mode} <= rows[i][5:4];
            step(1);
            check({o_suspend_n, !powered, o_self_powered, o_test_active}, rows[i][3:0]);
        end
        @(posedge i_clk);
        i_usb <= '0;
        {i_power_source_select, i_test_mode} <= 2'h0;
        i_usb_bus_reset <= 1;
        step(3);
        check({3'h0, held}, 4'h0);
        check({1'b0, o_tx_activity_lamp_n, o_rx_activity_lamp_n, o_reset_out}, 4'h1);
        @(posedge i_clk);
        i_ext_reset_n <= 0;
        step(1);
        check({3'h0, held}, 4'h1);
        @(posedge i_clk);
        i_ext_reset_n <= 1;
        i_usb_bus_reset <= 0;
        hold_check();
        for (int k = 0; k < 2; k++) begin
            @(posedge i_clk);
            i_usb <= 4'h2 >> k;
            @(posedge i_clk);
            i_usb <= '0;
            step(PULSE - 1);
            check({2'h0, o_tx_activity_lamp_oe_n, o_rx_activity_lamp_oe_n}, 4'h1 << k);
            step(2);
            check({2'h0, o_tx_activity_lamp_oe_n, o_rx_activity_lamp_oe_n}, 4'h3);
        end
        @(posedge i_clk);
        i_usb <= 4'h4;
        step(3);
        last = o_osc_out;
        step(12);
        check({3'h0, o_osc_out}, {3'h0, last});
        @(posedge i_clk);
        i_usb <= '0;
        step(6);
        flips = 0;
        repeat (16) begin
            last = o_osc_out;
            step(1);
            flips += (o_osc_out !== last);
        end
        check(flips[3:0], 4'h4);
        finish_test();
    end
endmodule // testbench
`default_nettype wire
